//--- logic/pipe_status_events.sv
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
module pipe_status_events
  import pipe_status_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [BE_W-1:0]   avs_byteenable_in,
  output logic [DATA_W-1:0]      avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // event sources, one-cycle pulses
  input  wire logic              fifo_underrun_in,
  input  wire logic              crc_error_in,
  input  wire logic              crc_done_in,
  input  wire logic              serial_bus_event_in,
  input  wire logic              vsync_in,
  input  wire logic              line_compare_in,
  input  wire logic              backlight_cfg_write_in,
  input  wire logic              vblank_start_in,
  input  wire logic              frame_start_in,
  input  wire logic              overlay_update_in,
  input  wire logic              line_start_in,
  // field and mode levels
  input  wire logic              field_odd_in,
  input  wire logic [2:0]        interlace_mode_in,
  // first-level status
  output logic                   pipe_event_out,
  // dithering controls
  output logic                   dither_enable_out,
  output logic [1:0]             dither_type_out,
  output logic                   dither_acc_reset_out,
  // gamma maximum points
  output logic [GAMMA_W-1:0]     gamma_max_red_out,
  output logic [GAMMA_W-1:0]     gamma_max_green_out,
  output logic [GAMMA_W-1:0]     gamma_max_blue_out
);

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  logic                  wait_q;
  logic                  req;
  logic                  wr_acc;
  logic [DATA_W-1:0]     wmask;
  logic                  hit_conf;
  logic                  hit_red;
  logic                  hit_green;
  logic                  hit_blue;
  logic                  hit_status;
  logic [DATA_W-1:0]     rdata_d;
  logic [DATA_W-1:0]     rdata_q;

  assign req        = avs_read_in | avs_write_in;
  // a request is answered exactly once, in the cycle wait drops
  assign wr_acc     = avs_write_in & ~wait_q;
  assign wmask      = lane_mask(avs_byteenable_in);
  assign hit_conf   = (avs_address_in == OFS_PIPE_CONF);
  assign hit_red    = (avs_address_in == OFS_GAMMA_RED);
  assign hit_green  = (avs_address_in == OFS_GAMMA_GREEN);
  assign hit_blue   = (avs_address_in == OFS_GAMMA_BLUE);
  assign hit_status = (avs_address_in == OFS_STATUS);

  // one wait cycle lets read data come from a flop
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_waitrequest_out = wait_q;

  // ****************************************************************
  // configuration and gamma registers
  // ****************************************************************
  logic [DATA_W-1:0]  conf_q;
  logic [GAMMA_W-1:0] gamma_red_q;
  logic [GAMMA_W-1:0] gamma_green_q;
  logic [GAMMA_W-1:0] gamma_blue_q;

  // only the dithering bits live here; the rest of the word reads zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      conf_q <= CONF_RESET;
    end else if (wr_acc && hit_conf) begin
      conf_q <= merge(conf_q, avs_writedata_in, wmask & CONF_MASK);
    end
  end

  // values above 1024.0 are stored as written; range is software's job
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      gamma_red_q   <= GAMMA_RESET;
      gamma_green_q <= GAMMA_RESET;
      gamma_blue_q  <= GAMMA_RESET;
    end else if (wr_acc) begin
      if (hit_red) begin
        gamma_red_q <= GAMMA_W'(merge({15'h0000, gamma_red_q}, avs_writedata_in, wmask));
      end
      if (hit_green) begin
        gamma_green_q <= GAMMA_W'(merge({15'h0000, gamma_green_q}, avs_writedata_in, wmask));
      end
      if (hit_blue) begin
        gamma_blue_q <= GAMMA_W'(merge({15'h0000, gamma_blue_q}, avs_writedata_in, wmask));
      end
    end
  end

  assign gamma_max_red_out   = gamma_red_q;
  assign gamma_max_green_out = gamma_green_q;
  assign gamma_max_blue_out  = gamma_blue_q;
  assign dither_enable_out   = conf_q[BIT_DITHER_EN];
  assign dither_type_out     = conf_q[DITHER_TYPE_LSB +: 2];

  // ****************************************************************
  // field events and dither frame sequencing
  // ****************************************************************
  logic odd_evt;
  logic even_evt;

  field_event_gen u_field (
    .mclk_in           (mclk_in),
    .rst_in            (rst_in),
    .vblank_start_in   (vblank_start_in),
    .line_start_in     (line_start_in),
    .field_odd_in      (field_odd_in),
    .interlace_mode_in (interlace_mode_in),
    .odd_evt_out       (odd_evt),
    .even_evt_out      (even_evt)
  );

  dither_frame_seq u_dither (
    .mclk_in         (mclk_in),
    .rst_in          (rst_in),
    .acc_reset_en_in (conf_q[BIT_ACC_RESET]),
    .frame_start_in  (frame_start_in),
    .acc_reset_out   (dither_acc_reset_out)
  );

  // ****************************************************************
  // event status and enables
  // ****************************************************************
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] enable_q;
  logic [DATA_W-1:0] evt;
  logic [DATA_W-1:0] clr;
  logic              pipe_event_q;

  always_comb begin
    evt                = '0;
    evt[BIT_UNDERRUN]  = fifo_underrun_in;
    evt[BIT_CRC_ERR]   = crc_error_in;
    evt[BIT_CRC_DONE]  = crc_done_in;
    evt[BIT_SERIAL]    = serial_bus_event_in;
    evt[BIT_VSYNC]     = vsync_in;
    evt[BIT_LINE_CMP]  = line_compare_in;
    evt[BIT_BACKLIGHT] = backlight_cfg_write_in;
    evt[BIT_ODD]       = odd_evt;
    evt[BIT_EVEN]      = even_evt;
    evt[BIT_VBL_START] = vblank_start_in;
    evt[BIT_FRAME_ST]  = frame_start_in;
    evt[BIT_OVERLAY]   = overlay_update_in;
  end

  // write-one-to-clear, limited to enabled byte lanes
  assign clr = (wr_acc && hit_status) ? (avs_writedata_in & wmask & STICKY_MASK) : '0;

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= (status_q & ~clr) | (evt & STICKY_MASK);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      enable_q <= STATUS_RESET;
    end else if (wr_acc && hit_status) begin
      enable_q <= merge(enable_q, avs_writedata_in, wmask & ENABLE_MASK);
    end
  end

  // underrun sits in the upper half and is left out of the reduction
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pipe_event_q <= 1'b0;
    end else begin
      pipe_event_q <= |(status_q[15:0] & enable_q[ENABLE_SHIFT +: 16]);
    end
  end

  assign pipe_event_out = pipe_event_q;

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    rdata_d = '0;
    if (hit_conf) begin
      rdata_d = conf_q & CONF_MASK;
    end else if (hit_red) begin
      rdata_d = {15'h0000, gamma_red_q};
    end else if (hit_green) begin
      rdata_d = {15'h0000, gamma_green_q};
    end else if (hit_blue) begin
      rdata_d = {15'h0000, gamma_blue_q};
    end else if (hit_status) begin
      rdata_d = (status_q & STICKY_MASK) | (enable_q & ENABLE_MASK);
    end
  end

  // unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (avs_read_in && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_out = rdata_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_EVENT_OUT_OR: assert property (
    ##1 pipe_event_q == $past(|(status_q[15:0] & enable_q[31:16])))
    else $error("pipe event output not the gated OR of status");

  AST_UNDERRUN_ISOLATED: assert property (
    ((status_q & ENABLE_MASK >> ENABLE_SHIFT & enable_q[31:16]) == '0) |=> !pipe_event_q)
    else $error("underrun or disabled flag reached event output");

  AST_UNDERRUN_SET: assert property (
    fifo_underrun_in |=> status_q[BIT_UNDERRUN])
    else $error("underrun flag not set");

  AST_STICKY_HOLD: assert property (
    status_q[BIT_VSYNC] && !clr[BIT_VSYNC] |=> status_q[BIT_VSYNC])
    else $error("sticky vsync flag dropped without a one write");

  AST_W1C_VSYNC: assert property (
    clr[BIT_VSYNC] && !vsync_in |=> !status_q[BIT_VSYNC])
    else $error("vsync flag not cleared by one write");

  AST_VSYNC_WINS: assert property (
    vsync_in |=> status_q[BIT_VSYNC])
    else $error("vsync event lost");

  AST_CRC_FLAGS: assert property (
    (crc_error_in || crc_done_in) |=> (status_q[BIT_CRC_ERR] || !$past(crc_error_in))
                                   && (status_q[BIT_CRC_DONE] || !$past(crc_done_in)))
    else $error("crc flag not captured");

  AST_VBLANK_FLAGS: assert property (
    vblank_start_in ##1 frame_start_in |-> status_q[BIT_VBL_START] ##1 status_q[BIT_FRAME_ST])
    else $error("blanking flags not set in order");

  AST_CAPTURE_DISABLED: assert property (
    line_compare_in && !enable_q[24] |=> status_q[BIT_LINE_CMP])
    else $error("disabled line compare event not captured");

  AST_GAMMA_STABLE: assert property (
    !(wr_acc && hit_red) |=> $stable(gamma_red_q))
    else $error("red gamma point changed without a write");

  AST_CONF_RESERVED: assert property (
    (conf_q & ~CONF_MASK) == '0)
    else $error("configuration bits outside dithering stored");

  AST_BUS_ANSWER: assert property (
    req && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus request not answered in one cycle");

  AST_UNDERRUN_W1C: assert property (
    clr[BIT_UNDERRUN] && !fifo_underrun_in |=> !status_q[BIT_UNDERRUN])
    else $error("underrun flag not cleared by one write");

  AST_SERIAL_SET: assert property (
    serial_bus_event_in |=> status_q[BIT_SERIAL])
    else $error("serial bus event not captured");

  AST_LINE_CMP_SET: assert property (
    line_compare_in |=> status_q[BIT_LINE_CMP])
    else $error("line compare event not captured");

  AST_BACKLIGHT_SET: assert property (
    backlight_cfg_write_in |=> status_q[BIT_BACKLIGHT])
    else $error("backlight config write not captured");

  AST_ODD_SET: assert property (
    odd_evt |=> status_q[BIT_ODD])
    else $error("odd field event not captured");

  AST_EVEN_SET: assert property (
    even_evt |=> status_q[BIT_EVEN])
    else $error("even field event not captured");

  AST_FRAME_START_SET: assert property (
    frame_start_in |=> status_q[BIT_FRAME_ST])
    else $error("frame start event not captured");

  AST_OVERLAY_SET: assert property (
    overlay_update_in |=> status_q[BIT_OVERLAY])
    else $error("overlay update event not captured");

  AST_ZERO_WRITE_KEEPS: assert property (
    wr_acc && hit_status && status_q[BIT_CRC_ERR] && !avs_writedata_in[BIT_CRC_ERR] |=> status_q[BIT_CRC_ERR])
    else $error("zero write cleared a sticky flag");

endmodule

//--- logic/pipe_status_pkg.sv
package pipe_status_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int          ADDR_W = 20;
  localparam int          DATA_W = 32;
  localparam int          BE_W   = 4;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [19:0] OFS_PIPE_CONF   = 20'h70008;
  localparam logic [19:0] OFS_GAMMA_RED   = 20'h70010;
  localparam logic [19:0] OFS_GAMMA_GREEN = 20'h70014;
  localparam logic [19:0] OFS_GAMMA_BLUE  = 20'h70018;
  localparam logic [19:0] OFS_STATUS      = 20'h70024;

  // ****************************************************************
  // gamma maximum points, 11.6 fixed point
  // ****************************************************************
  localparam int          GAMMA_W     = 17;
  localparam logic [16:0] GAMMA_RESET = 17'h10000;

  // ****************************************************************
  // pipe configuration, dithering bits only
  // ****************************************************************
  localparam int          BIT_DITHER_EN    = 4;
  localparam int          DITHER_TYPE_LSB  = 2;
  localparam int          BIT_ACC_RESET    = 1;
  localparam logic [31:0] CONF_MASK        = 32'h0000001E;
  localparam logic [31:0] CONF_RESET       = 32'h00000000;
  localparam logic [1:0]  DITHER_SPATIAL   = 2'h0;
  localparam logic [1:0]  DITHER_ST1       = 2'h1;
  localparam logic [1:0]  DITHER_ST2       = 2'h2;
  localparam logic [1:0]  DITHER_TEMPORAL  = 2'h3;
  localparam int          FRAME_CNT_W      = 3;
  localparam logic [2:0]  FRAME_CNT_LAST   = 3'h7;

  // ****************************************************************
  // event status and enable layout
  // ****************************************************************
  localparam logic [31:0] STATUS_RESET  = 32'h00000000;
  localparam logic [31:0] STICKY_MASK   = 32'h80003B77;
  localparam logic [31:0] ENABLE_MASK   = 32'h3B770000;
  localparam int          ENABLE_SHIFT  = 16;
  localparam int          BIT_UNDERRUN  = 31;
  localparam int          BIT_CRC_ERR   = 13;
  localparam int          BIT_CRC_DONE  = 12;
  localparam int          BIT_SERIAL    = 11;
  localparam int          BIT_VSYNC     = 9;
  localparam int          BIT_LINE_CMP  = 8;
  localparam int          BIT_BACKLIGHT = 6;
  localparam int          BIT_ODD       = 5;
  localparam int          BIT_EVEN      = 4;
  localparam int          BIT_VBL_START = 2;
  localparam int          BIT_FRAME_ST  = 1;
  localparam int          BIT_OVERLAY   = 0;

  // ****************************************************************
  // interlace modes
  // ****************************************************************
  localparam int          BIT_INTERLACED   = 2;
  localparam logic [2:0]  MODE_FIELD0_ONLY = 3'h7;

  // expand byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // byte-lane write merge limited to implemented bits
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

endpackage

//--- logic/field_event_gen.sv
`timescale 1ns/10ps
module field_event_gen
  import pipe_status_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // pipe timing
  input  wire logic       vblank_start_in,
  input  wire logic       line_start_in,
  input  wire logic       field_odd_in,
  input  wire logic [2:0] interlace_mode_in,
  // field events
  output logic            odd_evt_out,
  output logic            even_evt_out
);

  typedef enum logic [0:0] {IDLE, WAIT_LINE} fstate_t;

  fstate_t state_q;
  logic    odd_q;
  logic    fields_ok;

  // field flags only exist in interlaced modes other than field-0-only
  assign fields_ok = interlace_mode_in[BIT_INTERLACED] && (interlace_mode_in != MODE_FIELD0_ONLY);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= IDLE;
      odd_q   <= 1'b0;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (vblank_start_in) begin
            state_q <= WAIT_LINE;
            odd_q   <= field_odd_in;
          end
        end
        WAIT_LINE: begin
          if (line_start_in) begin
            state_q <= IDLE;
          end
        end
      endcase
    end
  end

  // one line after blanking starts
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      odd_evt_out  <= 1'b0;
      even_evt_out <= 1'b0;
    end else begin
      odd_evt_out  <= (state_q == WAIT_LINE) && line_start_in && fields_ok && odd_q;
      even_evt_out <= (state_q == WAIT_LINE) && line_start_in && fields_ok && !odd_q;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_FIELD0_SILENT: assert property (
    (interlace_mode_in == MODE_FIELD0_ONLY) |=> !odd_evt_out && !even_evt_out)
    else $error("field flag raised in field-0-only mode");

  AST_FIELD_ONE_LINE: assert property (
    (odd_evt_out || even_evt_out) |-> $past(line_start_in) && !$past(state_q == IDLE))
    else $error("field event not one line after blanking start");

endmodule

//--- logic/dither_frame_seq.sv
`timescale 1ns/10ps
module dither_frame_seq
  import pipe_status_pkg::*;
(
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // control and timing
  input  wire logic acc_reset_en_in,
  input  wire logic frame_start_in,
  // accumulator restart
  output logic      acc_reset_out
);

  logic [FRAME_CNT_W-1:0] cnt_q;

  // counter held at zero while disabled so the first restart is the 8th frame
  always_ff @(posedge mclk_in) begin
    if (rst_in || !acc_reset_en_in) begin
      cnt_q <= '0;
    end else if (frame_start_in) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      acc_reset_out <= 1'b0;
    end else begin
      acc_reset_out <= acc_reset_en_in && frame_start_in && (cnt_q == FRAME_CNT_LAST);
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_ACC_RESET_EIGHTH: assert property (
    acc_reset_out |-> $past(frame_start_in) && ($past(cnt_q) == FRAME_CNT_LAST) && $past(acc_reset_en_in))
    else $error("accumulator restart not on 8th frame");

  AST_ACC_RESET_OFF: assert property (
    !acc_reset_en_in |=> !acc_reset_out)
    else $error("accumulator restart while disabled");

endmodule

//--- verif/ident_model.sv
`timescale 1ns/10ps
module ident_model (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // pipe side and software side
  input  wire logic pipe_event_in,
  input  wire logic clear_in,
  output logic      ident_out
);
  // ****************************************************************
  // first-level identity bit for the pipe
  // ****************************************************************
  // a clear loses against a still-active pipe bit, so the pipe status must be cleared first
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ident_out <= 1'b0;
    end else begin
      ident_out <= pipe_event_in | (ident_out & ~clear_in);
    end
  end
endmodule

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import pipe_status_pkg::*;
  // ****************************************************************
  // stimulus, observation and model state
  // ****************************************************************
  logic        mclk = 0, rst = 1, rd = 0, wr = 0, lstart = 0, fodd = 0, iclr = 0;
  logic [19:0] addr = '0;
  logic [31:0] wdat = '0, rdat, sts_m = '0, en_m = '0, q;
  logic [3:0]  be = 4'hF;
  logic [9:0]  ev = '0;
  logic [2:0]  imode = '0;
  logic        wq, pev, den, dacc, ident, a;
  logic [1:0]  dtyp;
  logic [16:0] gr, gg, gb, gv[3];
  logic [19:0] gofs[3] = '{OFS_GAMMA_RED, OFS_GAMMA_GREEN, OFS_GAMMA_BLUE};
  logic [2:0]  modes[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  int          mismatches = 0, checks = 0;
  int          ebit[10] = '{31, 13, 12, 11, 9, 8, 6, 2, 1, 0};
  always #4 mclk = ~mclk;
  pipe_status_events i_pipe_status_events (
    .mclk_in(mclk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
    .fifo_underrun_in(ev[0]), .crc_error_in(ev[1]), .crc_done_in(ev[2]), .serial_bus_event_in(ev[3]),
    .vsync_in(ev[4]), .line_compare_in(ev[5]), .backlight_cfg_write_in(ev[6]), .vblank_start_in(ev[7]),
    .frame_start_in(ev[8]), .overlay_update_in(ev[9]), .line_start_in(lstart), .field_odd_in(fodd),
    .interlace_mode_in(imode), .pipe_event_out(pev), .dither_enable_out(den), .dither_type_out(dtyp),
    .dither_acc_reset_out(dacc), .gamma_max_red_out(gr), .gamma_max_green_out(gg), .gamma_max_blue_out(gb));
  ident_model i_ident_model (.mclk_in(mclk), .rst_in(rst), .pipe_event_in(pev), .clear_in(iclr),
    .ident_out(ident));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one access; an idle edge follows so the next request never shares a time step with this release
  task automatic bus(input logic w, input logic [19:0] ad, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    addr <= ad; wdat <= d; be <= b; wr <= w; rd <= ~w;
    do begin
      @(posedge mclk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    q = rdat;
    if (n >= 20) chk("waitrequest", 0, 1);
    rd <= 0; wr <= 0;
    @(posedge mclk);
  endtask
  task automatic verify;
    bus(0, OFS_STATUS, 0, 4'hF);
    chk("status", sts_m | en_m, q);
    chk("pipe_event", |(sts_m[15:0] & en_m[31:16]), pev);
  endtask
  task automatic wr_sts(input logic [31:0] d, input logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    bus(1, OFS_STATUS, d, b);
    sts_m &= ~(d & m & STICKY_MASK);
    en_m = (en_m & ~(m & ENABLE_MASK)) | (d & m & ENABLE_MASK);
    verify();
  endtask
  task automatic pulse(input int i);
    ev <= 10'h1 << i;
    @(posedge mclk);
    ev <= '0;
    @(posedge mclk);
    sts_m[ebit[i]] = 1'b1;
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(36));
    repeat (6) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    // ****************************************************************
    // reset values, unmapped place, gamma points
    // ****************************************************************
    bus(0, OFS_PIPE_CONF, 0, 4'hF);
    chk("conf reset", 0, q);
    bus(0, 20'h7001C, 0, 4'hF);
    chk("unmapped", 0, q);
    verify();
    for (int k = 0; k < 3; k++) begin
      bus(0, gofs[k], 0, 4'hF);
      chk("gamma reset", GAMMA_RESET, q);
      gv[k] = $urandom_range(32'h10000, 0);
      bus(1, gofs[k], ($urandom & 32'hFFFE0000) | gv[k], 4'hF);
      bus(0, gofs[k], 0, 4'hF);
      chk("gamma read", gv[k], q);
    end
    chk("gamma out", {gv[0], gv[1], gv[2]}, {gr, gg, gb});
    for (int t = 0; t < 4; t++) begin
      bus(1, OFS_PIPE_CONF, {27'h0, t[0], t[1:0], 2'h1}, 4'hF);
      bus(0, OFS_PIPE_CONF, 0, 4'hF);
      chk("conf read", {27'h0, t[0], t[1:0], 2'h0}, q);
      chk("dither out", {t[0], t[1:0]}, {den, dtyp});
    end
    bus(1, OFS_PIPE_CONF, 0, 4'hF);
    // ****************************************************************
    // sticky flags, enables and write-one clear
    // ****************************************************************
    repeat (3) begin
      wr_sts($urandom & ENABLE_MASK & ~32'h00300000, 4'hF);
      for (int i = 0; i < 10; i++) begin
        pulse(i);
        verify();
      end
      wr_sts(en_m, 4'hF);
      wr_sts(32'hFFFFFFFF, 4'h1);
      wr_sts(en_m | STICKY_MASK, 4'hF);
    end
    foreach (modes[k]) for (int f = 0; f < 2; f++) begin
      imode <= modes[k];
      fodd <= f[0];
      wr_sts((en_m & ~32'h00300000) | (modes[k][2] ? 32'h00300000 : 32'h0), 4'hF);
      pulse(7);
      lstart <= 1;
      @(posedge mclk);
      lstart <= 0;
      repeat (3) @(posedge mclk);
      if (modes[k][2] && modes[k] != 3'h7) sts_m[f ? BIT_ODD : BIT_EVEN] = 1'b1;
      verify();
      wr_sts(en_m | STICKY_MASK, 4'hF);
    end
    // ****************************************************************
    // accumulator restart, then identity clear order
    // ****************************************************************
    bus(1, OFS_PIPE_CONF, 32'h2, 4'hF);
    for (int i = 1; i <= 24; i++) begin
      if (i == 17) bus(1, OFS_PIPE_CONF, 0, 4'hF);
      ev <= 10'h100;
      @(posedge mclk);
      ev <= '0;
      @(posedge mclk);
      a = dacc;
      @(posedge mclk);
      chk("acc reset", i <= 16 && i % 8 == 0, a | dacc);
    end
    ev <= 10'h080;
    @(posedge mclk);
    ev <= 10'h100;
    @(posedge mclk);
    ev <= '0;
    @(posedge mclk);
    sts_m[BIT_VBL_START] = 1'b1;
    sts_m[BIT_FRAME_ST] = 1'b1;
    verify();
    wr_sts(32'h02000000 | STICKY_MASK, 4'hF);
    pulse(4);
    verify();
    chk("ident set", 1, ident);
    // vsync lands on the very edge of the clearing write, so the set must win
    fork
      bus(1, OFS_STATUS, 32'h02000200, 4'hF);
      begin
        @(posedge mclk);
        ev <= 10'h010;
        @(posedge mclk);
        ev <= '0;
      end
    join
    verify();
    wr_sts(32'h02000200, 4'hF);
    iclr <= 1;
    @(posedge mclk);
    iclr <= 0;
    repeat (2) @(posedge mclk);
    chk("ident clear", 0, ident);
    give_verdict();
  end
endmodule
